// [rtl/dds_ctrl.sv]
/*
  dds_ctrl: pin control, serial word input, phase accumulator and sign-bit output of a dds.
  assumes an apb master on pclk, a host driving the serial link on link_sclk,
  and asynchronous device pins that are synchronised here.
*/
//
// Overview of operation
// RL1: frequency select picks frequency word a or b
// RL2: frequency choice from pin or control bit
// RL3: phase select picks phase offset a or b
// RL4: phase choice from pin or control bit
// RL5: reset pin clears accumulator, output midscale
// RL6: reset pin leaves addressable registers unchanged
// RL7: sleep pin high powers dac down
// RL8: sleep pin equals dac powerdown bit
// RL9: each serial transfer carries one 16-bit word
// RL10: data sampled on serial clock falling edge
// RL11: frame sync low starts word loading
// RL12: sign output driven only when enabled
// RL13: select bit picks comparator or nco msb
// RL14: enable and select connect comparator input
// RL15: output frequency is fraction of master clock
// RL16: 28-bit accumulator adds word, wraps
// RL17: 12-bit phase added to accumulator msbs
// RL18: frequency switch keeps phase continuous
// RL19: word taken only after sixteen bits
`timescale 1ns/1ns
module dds_ctrl
  import dds_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  input  wire logic        link_sclk,
  input  wire logic        serial_data_in,
  input  wire logic        frame_sync_n,
  // device pins
  input  wire logic        freq_reg_select_pin,
  input  wire logic        phase_reg_select_pin,
  input  wire logic        dds_reset_pin,
  input  wire logic        sleep_pin,
  input  wire logic        comparator_input_pin,
  // datapath and analog control
  output logic [PH_W-1:0]  dac_phase_word,
  output logic             dac_powerdown,
  output logic             sign_bit_out,
  output logic             sign_bit_oe,
  output logic             comparator_connect
);
  // link domain state
  logic [CNT_W-1:0] bit_cnt_q;
  logic [SER_W-1:0] shift_q;
  logic [SER_W-1:0] link_word_q;
  logic             link_tgl_q;

  // pclk domain state
  dds_pins_s          pins_raw;
  dds_pins_s          pins_s;
  logic               tgl_s;
  logic               tgl_seen_q;
  logic [CTRL_W-1:0]  ctrl_q;
  logic [ACC_W-1:0]   frequency_word_a_q;
  logic [ACC_W-1:0]   frequency_word_b_q;
  logic [PH_W-1:0]    phase_offset_a_q;
  logic [PH_W-1:0]    phase_offset_b_q;
  logic [ACC_W-1:0]   acc_q;
  logic [SER_W-1:0]   rx_word_q;
  logic               rx_flag_q;
  logic [RXCNT_W-1:0] rx_cnt_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [PH_W-1:0]    phase_q;
  logic               pwrdn_q;
  logic               sign_q;
  logic               sign_oe_q;
  logic               cmp_conn_q;

  // serial shift: falling edge, counter held clear while frame sync is high
  always_ff @(negedge link_sclk or posedge frame_sync_n) begin
    if (frame_sync_n) begin // RL11
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != CNT_W'(SER_W)) begin
      bit_cnt_q <= bit_cnt_q + CNT_W'(1); // RL9
    end
  end

  always_ff @(negedge link_sclk) begin
    shift_q <= {shift_q[SER_W-2:0], serial_data_in}; // RL10
  end

  // word latched and announced by toggle on the sixteenth bit only
  always_ff @(negedge link_sclk or negedge presetn) begin
    if (!presetn) begin
      link_word_q <= WORD_RST;
      link_tgl_q  <= 1'b0;
    end else if (!frame_sync_n && bit_cnt_q == CNT_W'(SER_W - 1)) begin // RL19
      link_word_q <= {shift_q[SER_W-2:0], serial_data_in};
      link_tgl_q  <= ~link_tgl_q;
    end
  end

  // crossings into pclk
  assign pins_raw = '{freq_select_bit:  freq_reg_select_pin,
                      psel:  phase_reg_select_pin,
                      rst:   dds_reset_pin,
                      sleep: sleep_pin,
                      cmp:   comparator_input_pin};

  dds_sync2 #(.W($bits(dds_pins_s))) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_raw),
    .q     (pins_s)
  );

  dds_sync2 #(.W(1)) u_tgl_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link_tgl_q),
    .q     (tgl_s)
  );

  // apb decode
  wire        setup_ph   = psel & ~penable;
  wire        access_ok  = psel & penable & pready_q;
  wire        wr_en      = access_ok & pwrite;
  wire        hit_ctrl   = (paddr == OFF_CTRL);
  wire        hit_fa     = (paddr == OFF_FREQ_A);
  wire        hit_fb     = (paddr == OFF_FREQ_B);
  wire        hit_pa     = (paddr == OFF_PHASE_A);
  wire        hit_pb     = (paddr == OFF_PHASE_B);
  wire        hit_stat   = (paddr == OFF_STATUS);
  wire        hit_rx     = (paddr == OFF_RXWORD);
  wire        hit_acc    = (paddr == OFF_ACC);
  wire        mapped     = hit_ctrl | hit_fa | hit_fb | hit_pa | hit_pb |
                           hit_stat | hit_rx | hit_acc;
  wire        new_word   = tgl_s ^ tgl_seen_q;
  wire        flag_clr   = wr_en & hit_stat & pwdata[SB_RXFLAG];

  // source selection
  wire        pin_src    = ctrl_q[CB_PINSRC];
  wire        freq_select_bit_act   = pin_src ? pins_s.freq_select_bit : ctrl_q[CB_FREQ_SELECT_BIT]; // RL2
  wire        psel_act   = pin_src ? pins_s.psel : ctrl_q[CB_PSEL]; // RL4
  wire [ACC_W-1:0] freq_act  = freq_select_bit_act ? frequency_word_b_q : frequency_word_a_q; // RL1
  wire [PH_W-1:0]  phase_act = psel_act ? phase_offset_b_q : phase_offset_a_q; // RL3
  wire        opben      = ctrl_q[CB_OPEN];
  wire        cmpsel     = ctrl_q[CB_CMPSEL];

  wire [31:0] status_w   = {{(32 - SB_CNT_LO - RXCNT_W){1'b0}}, rx_cnt_q, 4'h0,
                            pwrdn_q, psel_act, freq_select_bit_act, rx_flag_q};
  wire [31:0] rdata_w    = hit_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl_q} :
                           hit_fa   ? {{(32 - ACC_W){1'b0}}, frequency_word_a_q} :
                           hit_fb   ? {{(32 - ACC_W){1'b0}}, frequency_word_b_q} :
                           hit_pa   ? {{(32 - PH_W){1'b0}}, phase_offset_a_q} :
                           hit_pb   ? {{(32 - PH_W){1'b0}}, phase_offset_b_q} :
                           hit_stat ? status_w :
                           hit_rx   ? {{(32 - SER_W){1'b0}}, rx_word_q} :
                           hit_acc  ? {{(32 - ACC_W){1'b0}}, acc_q} : 32'h00000000;

  // apb answer: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      prdata_q  <= (setup_ph & ~pwrite) ? rdata_w : 32'h00000000;
    end
  end

  // addressable registers, untouched by the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q             <= CTRL_RST;
      frequency_word_a_q <= FREQ_RST;
      frequency_word_b_q <= FREQ_RST;
      phase_offset_a_q   <= PHASE_RST;
      phase_offset_b_q   <= PHASE_RST;
    end else if (wr_en) begin // RL6
      if (hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
      if (hit_fa) frequency_word_a_q <= pwdata[ACC_W-1:0];
      if (hit_fb) frequency_word_b_q <= pwdata[ACC_W-1:0];
      if (hit_pa) phase_offset_a_q <= pwdata[PH_W-1:0];
      if (hit_pb) phase_offset_b_q <= pwdata[PH_W-1:0];
    end
  end

  // received serial words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_seen_q <= 1'b0;
      rx_word_q  <= WORD_RST;
      rx_flag_q  <= 1'b0;
      rx_cnt_q   <= '0;
    end else begin
      tgl_seen_q <= tgl_s;
      if (new_word) begin // RL19
        rx_word_q <= link_word_q;
        rx_cnt_q  <= rx_cnt_q + RXCNT_W'(1);
      end
      rx_flag_q <= new_word | (rx_flag_q & ~flag_clr);
    end
  end

  // phase accumulator and phase adder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= '0;
      phase_q <= '0;
    end else if (pins_s.rst) begin // RL5
      acc_q   <= '0;
      phase_q <= '0;
    end else begin
      acc_q   <= acc_q + freq_act; // RL15 RL16 RL18
      phase_q <= acc_q[ACC_W-1 -: PH_W] + phase_act; // RL17
    end
  end

  // dac power and sign-bit output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrdn_q    <= 1'b0;
      sign_q     <= 1'b0;
      sign_oe_q  <= 1'b0;
      cmp_conn_q <= 1'b0;
    end else begin
      pwrdn_q    <= pins_s.sleep | ctrl_q[CB_PWRDN]; // RL7 RL8
      sign_oe_q  <= opben; // RL12
      sign_q     <= opben & (cmpsel ? pins_s.cmp : acc_q[ACC_W-1]); // RL13
      cmp_conn_q <= opben & cmpsel; // RL14
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign dac_phase_word     = phase_q;
  assign dac_powerdown      = pwrdn_q;
  assign sign_bit_out       = sign_q;
  assign sign_bit_oe        = sign_oe_q;
  assign comparator_connect = cmp_conn_q;

  // checks
  property p_acc_clear;
    @(posedge pclk) disable iff (!presetn)
    pins_s.rst |=> (acc_q == '0) && (phase_q == '0);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared"); // RL5

  property p_regs_hold;
    @(posedge pclk) disable iff (!presetn)
    pins_s.rst && !wr_en |=> $stable(frequency_word_a_q) && $stable(ctrl_q);
  endproperty
  a_regs_hold: assert property (p_regs_hold) else $error("register changed by reset"); // RL6

  property p_acc_step;
    @(posedge pclk) disable iff (!presetn)
    !pins_s.rst |=> acc_q == ACC_W'($past(acc_q) + $past(freq_act));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // RL16

  property p_freq_pick;
    @(posedge pclk) disable iff (!presetn)
    !pin_src && !pins_s.rst ##0 ctrl_q[CB_FREQ_SELECT_BIT] |=>
      acc_q == ACC_W'($past(acc_q) + $past(frequency_word_b_q));
  endproperty
  a_freq_pick: assert property (p_freq_pick) else $error("frequency bit ignored"); // RL2

  property p_phase_add;
    @(posedge pclk) disable iff (!presetn)
    !pins_s.rst && !psel_act |=>
      phase_q == PH_W'($past(acc_q[ACC_W-1 -: PH_W]) + $past(phase_offset_a_q));
  endproperty
  a_phase_add: assert property (p_phase_add) else $error("phase sum wrong"); // RL17

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
    pins_s.sleep |=> dac_powerdown;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pin ignored"); // RL7

  property p_pwrdn_bit;
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[CB_PWRDN] || pins_s.sleep |=> dac_powerdown;
  endproperty
  a_pwrdn_bit: assert property (p_pwrdn_bit) else $error("powerdown bit ignored"); // RL8

  property p_oe_off;
    @(posedge pclk) disable iff (!presetn)
    !opben |=> !sign_bit_oe && !sign_bit_out && !comparator_connect;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sign output driven while off"); // RL12

  property p_msb_out;
    @(posedge pclk) disable iff (!presetn)
    opben && !cmpsel |=> sign_bit_out == $past(acc_q[ACC_W-1]);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("msb not on sign output"); // RL13

  property p_cmp_conn;
    @(posedge pclk) disable iff (!presetn)
    opben && cmpsel |=> comparator_connect && sign_bit_out == $past(pins_s.cmp);
  endproperty
  a_cmp_conn: assert property (p_cmp_conn) else $error("comparator not connected"); // RL14

  property p_rx_word;
    @(posedge pclk) disable iff (!presetn)
    new_word |=> rx_flag_q && rx_word_q == $past(link_word_q);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("serial word lost"); // RL19

  property p_freq_pin;
    @(posedge pclk) disable iff (!presetn)
    pin_src && !pins_s.rst ##0 pins_s.freq_select_bit |=>
      acc_q == ACC_W'($past(acc_q) + $past(frequency_word_b_q));
  endproperty
  a_freq_pin: assert property (p_freq_pin) else $error("frequency pin ignored"); // RL1

  property p_phase_b;
    @(posedge pclk) disable iff (!presetn)
    !pins_s.rst && psel_act |=>
      phase_q == PH_W'($past(acc_q[ACC_W-1 -: PH_W]) + $past(phase_offset_b_q));
  endproperty
  a_phase_b: assert property (p_phase_b) else $error("phase offset b not added"); // RL3

  property p_pwr_up;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[CB_PWRDN] && !pins_s.sleep |=> !dac_powerdown;
  endproperty
  a_pwr_up: assert property (p_pwr_up) else $error("dac powered down with no source"); // RL8

  property p_word_len;
    @(negedge link_sclk) disable iff (!presetn)
    frame_sync_n || bit_cnt_q != CNT_W'(SER_W - 1) |=> $stable(link_word_q);
  endproperty
  a_word_len: assert property (p_word_len) else $error("serial word taken early"); // RL19
endmodule

// [rtl/dds_pkg.sv]
/*
  dds_pkg: constants, register map and carrier types of the dds pin control block.
  assumes a 32-bit apb slave with byte addresses and one aligned word per register.
*/
package dds_pkg;
  // datapath widths
  localparam int ACC_W = 28;
  localparam int PH_W  = 12;
  localparam int SER_W = 16;
  localparam int CNT_W = 5;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FREQ_A  = 8'h04;
  localparam logic [7:0] OFF_FREQ_B  = 8'h08;
  localparam logic [7:0] OFF_PHASE_A = 8'h0c;
  localparam logic [7:0] OFF_PHASE_B = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_RXWORD  = 8'h18;
  localparam logic [7:0] OFF_ACC     = 8'h1c;

  // control register fields
  localparam int CTRL_W      = 6;
  localparam int CB_FREQ_SELECT_BIT     = 0;
  localparam int CB_PSEL     = 1;
  localparam int CB_PINSRC   = 2;
  localparam int CB_PWRDN    = 3;
  localparam int CB_OPEN     = 4;
  localparam int CB_CMPSEL   = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h04;

  // status register fields
  localparam int SB_RXFLAG = 0;
  localparam int SB_FACT   = 1;
  localparam int SB_PACT   = 2;
  localparam int SB_PWRDN  = 3;
  localparam int SB_CNT_LO = 8;
  localparam int RXCNT_W   = 8;

  // register reset values
  localparam logic [ACC_W-1:0] FREQ_RST  = 28'h0000000;
  localparam logic [PH_W-1:0]  PHASE_RST = 12'h000;
  localparam logic [SER_W-1:0] WORD_RST  = 16'h0000;

  // device pins, carried together through the synchroniser
  typedef struct packed {
    logic freq_select_bit;
    logic psel;
    logic rst;
    logic sleep;
    logic cmp;
  } dds_pins_s;
endpackage

// [rtl/dds_sync2.sv]
/*
  dds_sync2: two flip-flop level synchroniser of parameterised width.
  assumes d is quasi-static or gray-safe per bit; reset is asynchronous active low.
*/
`timescale 1ns/1ns
module dds_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// [sim/dds_host_model.sv]
/*
  dds_host_model: host side of the serial word link, msb first.
  assumes the bench calls send_word; sclk runs at 12 ns only inside a frame.
*/
`timescale 1ns/1ns
module dds_host_model (
  // serial link
  output logic link_sclk,
  output logic serial_data_in,
  output logic frame_sync_n
);
  // idle levels land in the nba region of time zero so the counter clear edge is seen
  initial begin
    link_sclk      <= 1'b1;
    serial_data_in <= 1'b0;
    frame_sync_n   <= 1'b1;
  end

  // frame of nbits, first bit is w[15]
  task automatic send_word(input logic [15:0] w, input int nbits);
    frame_sync_n = 1'b0;
    #6;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = w[15-i];
      #6 link_sclk = 1'b0;
      #6 link_sclk = 1'b1;
    end
    #3 frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #60;
  endtask
endmodule

// [sim/tb_top.sv]
/*
  tb_top: self-checking bench of dds_ctrl over apb, serial link and pins.
  assumes zero-wait apb answers and pin effects within three pclk edges.
*/
`timescale 1ns/1ns
module tb_top;
  import dds_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, a1, a2, da, db;
  logic pready, pslverr, e;
  logic sclk, sdi, fsn, fpin, ppin, rpin, spin, cpin;
  logic [PH_W-1:0] phw;
  logic pd, sbo, sboe, ccon;
  int fails, check_count;

  dds_host_model host (.link_sclk(sclk), .serial_data_in(sdi), .frame_sync_n(fsn));
  dds_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_sclk(sclk), .serial_data_in(sdi),
    .frame_sync_n(fsn), .freq_reg_select_pin(fpin), .phase_reg_select_pin(ppin),
    .dds_reset_pin(rpin), .sleep_pin(spin), .comparator_input_pin(cpin),
    .dac_phase_word(phw), .dac_powerdown(pd), .sign_bit_out(sbo),
    .sign_bit_oe(sboe), .comparator_connect(ccon));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, held until pready is seen high or 20 cycles pass, then the test stops as failed
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs();
    apb(0, OFF_CTRL, 0);
    chk(r, 32'h04);
    apb(0, OFF_STATUS, 0);
    chk(r, 32'h0);
    apb(1, 8'h20, 32'hff);
    chk(e, 1);
    apb(0, 8'h20, 0);
    chk({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_serial();
    int n;
    n = 0;
    host.send_word(16'ha5c3, 16);
    do begin
      apb(0, OFF_STATUS, 0);
      n++;
    end while (r[SB_RXFLAG] !== 1'b1 && n < 20);
    if (r[SB_RXFLAG] !== 1'b1) begin
      fails++;
      stop_test();
    end
    chk(r[15:8], 1);
    apb(0, OFF_RXWORD, 0);
    chk(r, 32'ha5c3);
    apb(1, OFF_STATUS, 1);
    host.send_word(16'h1234, 8);
    tick(10);
    apb(0, OFF_RXWORD, 0);
    chk(r, 32'ha5c3);
    apb(0, OFF_STATUS, 0);
    chk(r[15:0], 16'h0100);
    $display("test serial done");
  endtask

  task automatic acc_step(output logic [31:0] dv);
    apb(0, OFF_ACC, 0);
    a1 = r;
    apb(0, OFF_ACC, 0);
    a2 = r;
    dv = (a2 - a1) & 32'h0fffffff;
  endtask

  task automatic t_freq();
    apb(1, OFF_FREQ_A, 32'h10);
    apb(1, OFF_FREQ_B, 32'h30);
    apb(1, OFF_CTRL, 32'h00);
    acc_step(da);
    apb(1, OFF_CTRL, 32'h01);
    acc_step(db);
    chk(db, 3 * da);
    chk(da % 32'h10, 0);
    apb(1, OFF_CTRL, 32'h04);
    @(posedge pclk) fpin <= 1'b1;
    tick(4);
    acc_step(da);
    chk(da, db);
    $display("test freq done");
  endtask

  task automatic t_reset_phase();
    @(posedge pclk) rpin <= 1'b1;
    tick(4);
    apb(0, OFF_ACC, 0);
    chk(r, 0);
    chk(phw, 0);
    apb(0, OFF_FREQ_B, 0);
    chk(r, 32'h30);
    apb(1, OFF_FREQ_A, 0);
    apb(1, OFF_FREQ_B, 0);
    @(posedge pclk) rpin <= 1'b0;
    apb(1, OFF_PHASE_A, 32'h123);
    apb(1, OFF_PHASE_B, 32'h456);
    apb(1, OFF_CTRL, 32'h00);
    tick(4);
    chk(phw, 12'h123);
    apb(1, OFF_CTRL, 32'h02);
    tick(2);
    chk(phw, 12'h456);
    apb(1, OFF_CTRL, 32'h04);
    @(posedge pclk) ppin <= 1'b1;
    tick(4);
    chk(phw, 12'h456);
    $display("test reset phase done");
  endtask

  task automatic t_sleep_sign();
    @(posedge pclk) spin <= 1'b1;
    tick(4);
    chk(pd, 1);
    @(posedge pclk) spin <= 1'b0;
    tick(4);
    chk(pd, 0);
    apb(1, OFF_CTRL, 32'h0c);
    tick(2);
    chk(pd, 1);
    @(posedge pclk) cpin <= 1'b1;
    apb(1, OFF_CTRL, 32'h34);
    tick(4);
    chk({sboe, sbo, ccon}, 3'b111);
    apb(1, OFF_CTRL, 32'h14);
    tick(2);
    chk({sboe, sbo, ccon}, 3'b100);
    apb(1, OFF_CTRL, 32'h24);
    tick(2);
    chk({sboe, sbo, ccon}, 3'b000);
    $display("test sleep sign done");
  endtask

  initial begin
    presetn <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fpin, ppin, rpin, spin, cpin} = '0;
    fails = 0;
    check_count = 0;
    tick(12);
    presetn <= 1'b1;
    t_regs();
    t_serial();
    t_freq();
    t_reset_phase();
    t_sleep_sign();
    stop_test();
  end
endmodule
